// ---- srp_pkg.sv ----
`default_nettype none
package srp_pkg;

  // Security status bit positions
  localparam int SEC_PMSEL_BIT = 7;
  localparam int SEC_EFAIL_BIT = 6;
  localparam int SEC_PFAIL_BIT = 5;
  localparam int SEC_RSVD_BIT = 4;
  localparam int SEC_ESF_BIT = 3;
  localparam int SEC_PSF_BIT = 2;
  localparam int SEC_OLCK_BIT = 1;
  localparam int SEC_FLOCK_BIT = 0;

  // Reset values
  localparam logic VOLATILE_RST = 1'b0;
  localparam logic RSVD_VALUE = 1'b0;
  localparam logic SOL_RST = 1'b0;
  localparam logic DYN_RST = 1'b1;

  // Opcodes
  localparam logic [7:0] OPC_READ_SEC = 8'h2b;
  localparam logic [7:0] OPC_WRITE_SEC = 8'h2f;
  localparam logic [7:0] OPC_WENA = 8'h06;
  localparam logic [7:0] OPC_MODE_SEL = 8'h68;

  // Opcode phase length in link clocks
  localparam logic [3:0] OPC_LEN_SINGLE = 4'h8;
  localparam logic [3:0] OPC_LEN_QUAD = 4'h2;
  localparam logic [3:0] CNT_MAX = 4'hf;

  // Array geometry
  localparam int ADDR_W = 24;
  localparam int BLK_SHIFT = 16;
  localparam int SECT_SHIFT = 12;
  localparam int SECT_PER_BLK = 16;
  localparam int BP_ALL = 9;

  // Protection bit commands
  typedef enum logic [2:0] {
    PC_NONE = 3'b000,
    PC_SOL_SET = 3'b001,
    PC_SOL_ERASE = 3'b010,
    PC_DYN_WRITE = 3'b011,
    PC_GANG_LOCK = 3'b100,
    PC_GANG_UNLOCK = 3'b101
  } srp_pcmd_t;

  // Strap load sequence
  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_RUN = 2'b01
  } srp_state_t;

endpackage
`default_nettype wire

// ---- srp_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module srp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_q; // First stage, read by second only

  if (W < 1) begin : g_bad_w
    $error("srp_sync: W must be at least 1");
  end

  //////////////////////////////////////////////////////////////////////
  // Two flops; reset to zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end

endmodule
`default_nettype wire

// ---- srp_prot_map.sv ----
`timescale 1ns/1ns
`default_nettype none
module srp_prot_map #(
  parameter int AW = srp_pkg::ADDR_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Bit update port
  input wire srp_pkg::srp_pcmd_t cmd_i,
  input wire logic [AW-1:0] cmd_addr_i,
  input wire logic cmd_val_i,
  // Lookup port
  input wire logic [AW-1:0] chk_addr_i,
  output logic prot_o
);
  import srp_pkg::*;

  localparam int NBLK = 2 ** (AW - BLK_SHIFT);
  localparam int UNITS = 2 * SECT_PER_BLK + NBLK - 2;

  if (AW < BLK_SHIFT + 2 || AW > 31) begin : g_bad_aw
    $error("srp_prot_map: AW out of range");
  end

  logic sol_q [UNITS]; // Solid bits, emulated nonvolatile
  logic dyn_q [UNITS]; // Dynamic bits, volatile

  // Edge sectors get a bit each, the rest one per block
  function automatic int unit_of(input logic [AW-1:0] a);
    int blk;
    int sec;
    blk = int'(a[AW-1:BLK_SHIFT]);
    sec = int'(a[BLK_SHIFT-1:SECT_SHIFT]);
    if (blk == 0) begin
      return sec;
    end
    if (blk == NBLK - 1) begin
      return SECT_PER_BLK + NBLK - 2 + sec;
    end
    return SECT_PER_BLK + blk - 1;
  endfunction

  wire integer cmd_unit = unit_of(cmd_addr_i);
  wire integer chk_unit = unit_of(chk_addr_i);

  // Either bit set protects the unit
  assign prot_o = sol_q[chk_unit] | dyn_q[chk_unit]; // RL21

  //////////////////////////////////////////////////////////////////////
  // Bit updates; solid bits stay writable after reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < UNITS; i++) begin
        sol_q[i] <= SOL_RST; // RL22
        dyn_q[i] <= DYN_RST; // RL18
      end
    end else begin
      for (int i = 0; i < UNITS; i++) begin
        if (cmd_i == PC_SOL_ERASE) begin
          sol_q[i] <= 1'b0;
        end else if (cmd_i == PC_SOL_SET && i == cmd_unit) begin
          sol_q[i] <= 1'b1; // RL20
        end
        if (cmd_i == PC_GANG_LOCK) begin
          dyn_q[i] <= 1'b1;
        end else if (cmd_i == PC_GANG_UNLOCK) begin
          dyn_q[i] <= 1'b0;
        end else if (cmd_i == PC_DYN_WRITE && i == cmd_unit) begin
          dyn_q[i] <= cmd_val_i; // RL20
        end
      end
    end
  end

endmodule
`default_nettype wire

// ---- srp_top.sv ----
// Summary of operation
// [RL1] Security read answered anytime, repeats continuously
// [RL2] Read: opcode, then data until deselect
// [RL3] Opcode 8 clocks single, 2 quad
// [RL4] Write-enable must precede security write
// [RL5] Security write sets OTP lockdown bit1
// [RL6] Security write needs byte-exact deselect
// [RL7] Erase fail flag bit6, cleared on success
// [RL8] Program fail flag bit5, cleared on success
// [RL9] Erase suspended flag bit3 follows suspend
// [RL10] Program suspended flag bit2 follows suspend
// [RL11] OTP mode refuses main array access
// [RL12] Bit0 shows second OTP factory lock
// [RL13] Volatile bits reset zero; others one-time
// [RL14] Bit7 selects block or sector protection
// [RL15] Mode select sets bit7, never cleared
// [RL16] Mode select is opcode only, no data
// [RL17] Mode 0: block-protect field only
// [RL18] Mode 1: dynamic bits all set, field ignored
// [RL19] Mode 1: write-protect pin low protects all
// [RL20] One solid/dynamic bit per sector or block
// [RL21] Either bit set blocks program and erase
// [RL22] Solid bits stay modifiable after reset
// [RL23] Program into protected region not executed
// [RL24] Commands need write-enable, then clear it
// [RL25] Bit4 reads zero, ignores writes
`timescale 1ns/1ns
`default_nettype none
module srp_top #(
  parameter int AW = srp_pkg::ADDR_W
) (
  // Core clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // Serial link
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] sio_i,
  output logic [3:0] sio_o,
  output logic [3:0] sio_oe_o,
  // Link configuration
  input wire logic quad_command_mode_i,
  // One-time bits as stored
  input wire logic nv_protect_mode_i,
  input wire logic nv_otp_lockdown_i,
  input wire logic nv_factory_lock_i,
  // Write enable latch
  input wire logic wel_clear_i,
  output logic write_enable_latch_o,
  // Program and erase events
  input wire logic erase_done_i,
  input wire logic erase_ok_i,
  input wire logic program_done_i,
  input wire logic program_ok_i,
  input wire logic erase_suspend_i,
  input wire logic erase_resume_i,
  input wire logic program_suspend_i,
  input wire logic program_resume_i,
  // Secured OTP mode
  input wire logic otp_mode_i,
  output logic array_access_deny_o,
  output logic otp_area1_locked_o,
  // Protection configuration
  input wire logic write_protect_n_i,
  input wire logic [3:0] block_protect_field_i,
  input wire srp_pkg::srp_pcmd_t prot_cmd_i,
  input wire logic [AW-1:0] prot_addr_i,
  input wire logic prot_value_i,
  // Array operation check
  input wire logic op_req_i,
  input wire logic op_erase_i,
  input wire logic [AW-1:0] op_addr_i,
  output logic op_grant_o,
  output logic op_refuse_o,
  // Status
  output logic [7:0] security_status_o,
  output logic protect_mode_select_o
);
  import srp_pkg::*;

  if (AW < BLK_SHIFT + 4 || AW > 31) begin : g_bad_aw
    $error("srp_top: AW out of range");
  end

  //////////////////////////////////////////////////////////////////////
  // Link domain
  //////////////////////////////////////////////////////////////////////

  // Deselect clears the frame marker and line drivers without needing a clock edge
  wire logic frame_rst_n = reset_n_i & ~cs_n_i;

  logic [8:0] lk_sync; // Status and quad mode in link domain
  logic [7:0] sec_val; // Security value, core domain
  logic fresh_q; // No edge seen yet in this frame
  logic [3:0] clk_cnt_q; // Clocks in frame, saturating
  logic [3:0] clk_cnt_d;
  logic [7:0] op_sh_q; // Opcode shifter
  logic [7:0] op_sh_d;
  logic [7:0] cmd_q; // Opcode of last frame
  logic rd_act_q; // Status read data phase
  logic [2:0] pos_q; // Bit position in status byte
  logic [7:0] snap_q; // Byte being sent
  logic [3:0] out_q; // Data lines, falling edge
  logic [3:0] oe_q; // Enables, falling edge

  // Status and mode into the link clock
  srp_sync #(
    .W(9)
  ) u_lk_sync (
    .clk_i(sclk_i),
    .rst_n_i(reset_n_i),
    .d_i({quad_command_mode_i, sec_val}),
    .q_o(lk_sync)
  );

  // Link clock stops between frames: a new quad setting is only
  // seen from the second frame after it changes
  wire logic lk_quad = lk_sync[8];
  wire logic [7:0] lk_sec = lk_sync[7:0];
  // Single mode reads only line 0; upper lines ignored
  wire logic [3:0] lk_olen = lk_quad ? OPC_LEN_QUAD : OPC_LEN_SINGLE; // RL3
  wire logic [2:0] lk_step = lk_quad ? 3'h4 : 3'h1;
  wire logic [2:0] pos_nx = pos_q + lk_step;
  wire logic op_done = (clk_cnt_d == lk_olen);
  wire logic rd_hit = op_done & (op_sh_d == OPC_READ_SEC);

  // Count and opcode shift
  assign clk_cnt_d = fresh_q ? 4'h1 :
                     (clk_cnt_q == CNT_MAX) ? CNT_MAX : clk_cnt_q + 4'h1;
  assign op_sh_d = lk_quad ?
                   {(fresh_q ? 4'h0 : op_sh_q[3:0]), sio_i} : // RL3
                   {(fresh_q ? 7'h00 : op_sh_q[6:0]), sio_i[0]};

  // Per-frame start marker
  always_ff @(posedge sclk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      fresh_q <= 1'b1;
    end else begin
      fresh_q <= 1'b0;
    end
  end

  // Opcode capture; holds after deselect for the core to read
  always_ff @(posedge sclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      clk_cnt_q <= 4'h0;
      op_sh_q <= 8'h00;
      cmd_q <= 8'h00;
    end else begin
      clk_cnt_q <= clk_cnt_d;
      op_sh_q <= op_sh_d;
      if (op_done) begin
        cmd_q <= op_sh_d;
      end else if (fresh_q) begin
        cmd_q <= 8'h00; // Short frame must not replay an old opcode
      end
    end
  end

  // Read phase: no busy check, answered in any state
  always_ff @(posedge sclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_act_q <= 1'b0;
      pos_q <= 3'h0;
      snap_q <= 8'h00;
    end else if (fresh_q) begin
      rd_act_q <= 1'b0; // New frame, old read over
      pos_q <= 3'h0;
    end else if (rd_hit) begin
      rd_act_q <= 1'b1; // RL1
      pos_q <= 3'h0;
      snap_q <= lk_sec;
    end else if (rd_act_q) begin
      pos_q <= pos_nx;
      if (pos_nx == 3'h0) begin
        snap_q <= lk_sec; // RL1
      end
    end
  end

  // Bit or nibble at the current position
  wire logic bit_now = snap_q[3'h7 - pos_q];
  wire logic [3:0] nib_now = pos_q[2] ? snap_q[3:0] : snap_q[7:4];

  // Launch on falling edge; off as soon as deselected
  always_ff @(negedge sclk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      out_q <= 4'h0;
      oe_q <= 4'h0;
    end else if (rd_act_q && lk_quad) begin
      out_q <= nib_now; // RL2
      oe_q <= 4'hf;
    end else if (rd_act_q) begin
      out_q <= {2'b00, bit_now, 1'b0}; // RL2
      oe_q <= 4'h2;
    end else begin
      out_q <= 4'h0;
      oe_q <= 4'h0;
    end
  end

  assign sio_o = out_q;
  assign sio_oe_o = oe_q;

  //////////////////////////////////////////////////////////////////////
  // Core domain
  //////////////////////////////////////////////////////////////////////

  logic [1:0] pin_s; // Synced deselect and protect pin
  logic cs_prev_q; // Deselect, previous cycle
  srp_state_t st_q; // Strap load state
  srp_state_t st_d;
  logic wen_q; // Write enable latch
  logic pmsel_q; // Protection mode select
  logic olck_q; // OTP lockdown
  logic flock_q; // Factory lock of second OTP area
  logic efail_q; // Erase fail
  logic pfail_q; // Program fail
  logic esf_q; // Erase suspended
  logic psf_q; // Program suspended
  logic grant_q; // Operation granted
  logic refuse_q; // Operation refused
  logic map_prot; // Sector map protection

  srp_sync #(
    .W(2)
  ) u_pin_sync (
    .clk_i(ref_clk_i),
    .rst_n_i(reset_n_i),
    .d_i({cs_n_i, write_protect_n_i}),
    .q_o(pin_s)
  );

  wire logic cs_s = pin_s[1];
  wire logic wp_n_s = pin_s[0];

  // Link clock is idle after deselect, so the captured count and
  // opcode are steady by the time the synced edge appears here.
  // Limitation: a new frame must not start within four core cycles.
  wire logic frame_end = cs_s & ~cs_prev_q;
  wire logic [3:0] olen = quad_command_mode_i ? OPC_LEN_QUAD :
                                                OPC_LEN_SINGLE;
  wire logic exact = (clk_cnt_q == olen); // RL6
  wire logic cmd_ok = frame_end & exact;
  wire logic is_wena = cmd_ok & (cmd_q == OPC_WENA);
  wire logic is_wrsec = cmd_ok & (cmd_q == OPC_WRITE_SEC) & wen_q; // RL4
  // No address or data phase, so exact length is required
  wire logic is_modesel = cmd_ok & (cmd_q == OPC_MODE_SEL) & wen_q; // RL16

  // Block-protect region: top 2^(n-1) blocks for field n
  wire logic [AW-BLK_SHIFT:0] nblk = {1'b1, {(AW-BLK_SHIFT){1'b0}}};
  wire logic [AW-BLK_SHIFT:0] bp_span =
    (AW-BLK_SHIFT+1)'(1) << (block_protect_field_i - 4'h1);
  wire logic [AW-BLK_SHIFT:0] op_blk = {1'b0, op_addr_i[AW-1:BLK_SHIFT]};
  wire logic bp_prot =
    (block_protect_field_i == 4'h0) ? 1'b0 :
    (block_protect_field_i >= 4'(BP_ALL)) ? 1'b1 :
    (op_blk >= nblk - bp_span);

  // Mode picks exactly one protection source
  wire logic adv_prot = ~wp_n_s | map_prot; // RL19
  wire logic is_prot = pmsel_q ? adv_prot : bp_prot; // RL17
  // OTP mode shuts the array out entirely
  wire logic refuse = otp_mode_i | is_prot; // RL11
  wire logic prot_fail = op_req_i & is_prot & ~otp_mode_i;
  wire logic efail_set = (erase_done_i & ~erase_ok_i) |
                         (prot_fail & op_erase_i);
  wire logic pfail_set = (program_done_i & ~program_ok_i) |
                         (prot_fail & ~op_erase_i);

  // Sector bit commands only live in mode 1
  wire srp_pcmd_t pcmd = pmsel_q ? prot_cmd_i : PC_NONE; // RL18

  srp_prot_map #(
    .AW(AW)
  ) u_map (
    .clk_i(ref_clk_i),
    .rst_n_i(reset_n_i),
    .cmd_i(pcmd),
    .cmd_addr_i(prot_addr_i),
    .cmd_val_i(prot_value_i),
    .chk_addr_i(op_addr_i),
    .prot_o(map_prot)
  );

  assign st_d = (st_q == ST_LOAD) ? ST_RUN : st_q;

  // One-time bits: cleared under reset, loaded from store after release
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= ST_LOAD;
      pmsel_q <= 1'b0;
      olck_q <= 1'b0;
      flock_q <= 1'b0;
    end else begin
      st_q <= st_d;
      case (st_q)
        ST_LOAD: begin
          pmsel_q <= nv_protect_mode_i; // RL13
          olck_q <= nv_otp_lockdown_i;
          flock_q <= nv_factory_lock_i; // RL12
        end
        ST_RUN: begin
          // Only ever set; a set bit never returns to zero
          if (is_modesel) begin
            pmsel_q <= 1'b1; // RL15
          end
          if (is_wrsec) begin
            olck_q <= 1'b1; // RL5
          end
        end
        default: begin
          pmsel_q <= pmsel_q;
        end
      endcase
    end
  end

  // Write enable latch; consumed by the two commands
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wen_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      cs_prev_q <= cs_s;
      if (is_wena) begin
        wen_q <= 1'b1; // RL4
      end else if (is_wrsec || is_modesel || wel_clear_i) begin
        wen_q <= 1'b0; // RL24
      end
    end
  end

  // Fail flags; a new failure wins over a success
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      efail_q <= VOLATILE_RST; // RL13
      pfail_q <= VOLATILE_RST;
    end else begin
      if (efail_set) begin
        efail_q <= 1'b1; // RL7
      end else if (erase_done_i && erase_ok_i) begin
        efail_q <= 1'b0; // RL7
      end
      if (pfail_set) begin
        pfail_q <= 1'b1; // RL8
      end else if (program_done_i && program_ok_i) begin
        pfail_q <= 1'b0; // RL8
      end
    end
  end

  // Suspend flags; suspend wins over a same-cycle resume
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      esf_q <= VOLATILE_RST; // RL13
      psf_q <= VOLATILE_RST;
    end else begin
      if (erase_suspend_i) begin
        esf_q <= 1'b1; // RL9
      end else if (erase_resume_i) begin
        esf_q <= 1'b0; // RL9
      end
      if (program_suspend_i) begin
        psf_q <= 1'b1; // RL10
      end else if (program_resume_i) begin
        psf_q <= 1'b0; // RL10
      end
    end
  end

  // Answer each request one cycle later; flags never stall anything
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      grant_q <= 1'b0;
      refuse_q <= 1'b0;
    end else begin
      grant_q <= op_req_i & ~refuse; // RL21
      refuse_q <= op_req_i & refuse; // RL23
    end
  end

  // Register image; reserved bit tied low
  assign sec_val = {pmsel_q, efail_q, pfail_q, RSVD_VALUE, // RL25
                    esf_q, psf_q, olck_q, flock_q}; // RL14

  assign security_status_o = sec_val;
  assign protect_mode_select_o = pmsel_q;
  assign write_enable_latch_o = wen_q;
  assign array_access_deny_o = otp_mode_i;
  assign otp_area1_locked_o = olck_q;
  assign op_grant_o = grant_q;
  assign op_refuse_o = refuse_q;

endmodule
`default_nettype wire

// ---- srp_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
module srp_monitor #(
  parameter int AW = srp_pkg::ADDR_W
) (
  // Core clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // Pins
  input wire logic cs_n_i,
  input wire logic [3:0] sio_oe_o,
  input wire logic write_protect_n_i,
  input wire logic otp_mode_i,
  // Events
  input wire logic erase_suspend_i,
  input wire logic program_suspend_i,
  input wire logic program_resume_i,
  // Array check and status
  input wire logic op_req_i,
  input wire logic op_erase_i,
  input wire logic op_grant_o,
  input wire logic op_refuse_o,
  input wire logic [7:0] security_status_o,
  input wire logic protect_mode_select_o
);
  import srp_pkg::*;
  // One core domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////
  a_op_answer_once:
    assert property (op_req_i |=> op_grant_o ^ op_refuse_o)
    else $error("array check not answered exactly once");
  a_pfail_on_refuse:
    assert property (op_req_i && !op_erase_i && !otp_mode_i |=>
      (op_refuse_o |-> security_status_o[SEC_PFAIL_BIT]))
    else $error("refused program left fail flag clear");
  a_efail_on_refuse:
    assert property (op_req_i && op_erase_i && !otp_mode_i |=>
      (op_refuse_o |-> security_status_o[SEC_EFAIL_BIT]))
    else $error("refused erase left fail flag clear");
  a_esf_on_suspend:
    assert property (erase_suspend_i |=> security_status_o[SEC_ESF_BIT])
    else $error("erase suspend flag not set");
  a_psf_on_resume:
    assert property (program_resume_i && !program_suspend_i |=>
      !security_status_o[SEC_PSF_BIT])
    else $error("program suspend flag not cleared");
  a_otp_refuses_op:
    assert property (op_req_i && otp_mode_i |=> op_refuse_o)
    else $error("array access granted in otp mode");
  a_wp_low_refuse:
    assert property ((!write_protect_n_i)[*3] ##0
      (op_req_i && protect_mode_select_o) |=> op_refuse_o)
    else $error("write protect pin low did not refuse");
  a_mode_stays_set:
    assert property (protect_mode_select_o |=> protect_mode_select_o &&
      security_status_o[SEC_PMSEL_BIT])
    else $error("protection mode select fell back");
  a_rsvd_reads_zero:
    assert property (!security_status_o[SEC_RSVD_BIT])
    else $error("reserved status bit not zero");
  a_idle_no_drive:
    assert property (cs_n_i |-> sio_oe_o == 4'h0)
    else $error("data lines driven while deselected");
  // Main scenarios reached
  c_refuse: cover property (op_req_i ##1 op_refuse_o);
  c_mode_set: cover property ($rose(protect_mode_select_o));
  c_quad_read: cover property (sio_oe_o == 4'hf);
endmodule
bind srp_top srp_monitor #(.AW(AW)) i_srp_monitor (
  .ref_clk_i, .reset_n_i, .cs_n_i, .sio_oe_o, .write_protect_n_i,
  .otp_mode_i, .erase_suspend_i, .program_suspend_i, .program_resume_i,
  .op_req_i, .op_erase_i, .op_grant_o, .op_refuse_o, .security_status_o,
  .protect_mode_select_o
);
`default_nettype wire

// ---- srp_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module srp_host_model (
  // Command width
  input wire logic quad_i,
  // Link to the device
  output logic sclk_o,
  output logic cs_n_o,
  output logic [3:0] sio_o,
  input wire logic [3:0] sio_i
);
  // Clock stands low and device deselected between frames
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sio_o = 4'h5;
  end
  ////////////////////////////////////////
  // Frame: opcode, stray clocks, then nrd read units
  task automatic xfer(input logic [7:0] opc, input int extra,
                      input int nrd, output logic [7:0] rd);
    int n;
    logic [7:0] sh;
    begin
      n = quad_i ? 2 : 8;
      sh = opc;
      rd = 8'h00;
      // Odd offset keeps edges apart from the core clock
      #5 cs_n_o = 1'b0;
      for (int i = 0; i < n + extra + nrd * n; i++) begin
        if (i < n) begin
          // MSB first; unused upper lines keep moving
          sio_o = quad_i ? sh[7:4] : {~sio_o[3:1], sh[7]};
          sh = quad_i ? {sh[3:0], 4'h0} : {sh[6:0], 1'b0};
        end else begin
          sio_o = ~sio_o;
        end
        #16 sclk_o = 1'b1;
        // Device launched on the fall, so stable here
        if (i >= n + extra) begin
          rd = quad_i ? {rd[3:0], sio_i} : {rd[6:0], sio_i[1]};
        end
        #16 sclk_o = 1'b0;
      end
      #16 cs_n_o = 1'b1;
      sio_o = ~sio_o;
    end
  endtask
endmodule
`default_nettype wire

// ---- security_reg_protect_select_test.sv ----
`timescale 1ns/1ns
`default_nettype none
module security_reg_protect_select_test;
  import srp_pkg::*;
  `define CHK(what, exp, got) begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("wrong value %s exp %h got %h", what, exp, got); \
    end \
  end
  // Design pins, named as the ports
  logic ref_clk_i, reset_n_i, sclk_i, cs_n_i, quad_command_mode_i;
  logic [3:0] sio_i, sio_o, sio_oe_o, block_protect_field_i;
  logic nv_protect_mode_i, nv_otp_lockdown_i, nv_factory_lock_i;
  logic wel_clear_i, erase_done_i, erase_ok_i, program_done_i;
  logic program_ok_i, erase_suspend_i, erase_resume_i;
  logic program_suspend_i, program_resume_i, otp_mode_i;
  logic write_enable_latch_o, array_access_deny_o, otp_area1_locked_o;
  logic write_protect_n_i, prot_value_i, op_req_i, op_erase_i;
  logic op_grant_o, op_refuse_o, protect_mode_select_o;
  logic [23:0] prot_addr_i, op_addr_i;
  logic [7:0] security_status_o;
  srp_pcmd_t prot_cmd_i;
  logic [8:0] ev; // Pulse inputs, one bit each
  int failures, n_tests;
  assign {wel_clear_i, erase_done_i, erase_ok_i, program_done_i,
          program_ok_i, erase_suspend_i, erase_resume_i,
          program_suspend_i, program_resume_i} = ev;

  srp_top i_srp_top (
    .ref_clk_i, .reset_n_i, .sclk_i, .cs_n_i, .sio_i, .sio_o, .sio_oe_o,
    .quad_command_mode_i, .nv_protect_mode_i, .nv_otp_lockdown_i,
    .nv_factory_lock_i, .wel_clear_i, .write_enable_latch_o,
    .erase_done_i, .erase_ok_i, .program_done_i, .program_ok_i,
    .erase_suspend_i, .erase_resume_i, .program_suspend_i,
    .program_resume_i, .otp_mode_i, .array_access_deny_o,
    .otp_area1_locked_o, .write_protect_n_i, .block_protect_field_i,
    .prot_cmd_i, .prot_addr_i, .prot_value_i, .op_req_i, .op_erase_i,
    .op_addr_i, .op_grant_o, .op_refuse_o, .security_status_o,
    .protect_mode_select_o
  );
  srp_host_model i_srp_host_model (
    .quad_i(quad_command_mode_i), .sclk_o(sclk_i), .cs_n_o(cs_n_i),
    .sio_o(sio_i), .sio_i(sio_o)
  );
  // Core clock, 8 ns
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  ////////////////////////////////////////
  // All tasks start and end at a falling edge
  task automatic cmd(input logic [7:0] opc, input int extra);
    logic [7:0] d;
    begin
      i_srp_host_model.xfer(opc, extra, 0, d);
      repeat (10) @(negedge ref_clk_i); // Crossing delay plus gap
    end
  endtask
  task automatic chk_sec(input logic [7:0] e);
    logic [7:0] d;
    begin
      i_srp_host_model.xfer(OPC_READ_SEC, 0, 2, d);
      repeat (10) @(negedge ref_clk_i);
      `CHK("link status", e, d)
      `CHK("status port", e, security_status_o)
    end
  endtask
  task automatic op(input logic e, input logic [23:0] a, input logic rf);
    begin
      op_req_i = 1'b1;
      op_erase_i = e;
      op_addr_i = a;
      @(negedge ref_clk_i);
      op_req_i = 1'b0;
      `CHK("refuse", rf, op_refuse_o)
      `CHK("grant", ~rf, op_grant_o)
      @(negedge ref_clk_i);
    end
  endtask
  task automatic pulse(input logic [8:0] m);
    begin
      ev = m;
      @(negedge ref_clk_i);
      ev = 9'h000;
      @(negedge ref_clk_i);
    end
  endtask
  task automatic prot(input srp_pcmd_t c, input logic [23:0] a);
    begin
      prot_cmd_i = c;
      prot_addr_i = a;
      prot_value_i = 1'b1;
      @(negedge ref_clk_i);
      prot_cmd_i = PC_NONE;
      @(negedge ref_clk_i);
    end
  endtask
  task automatic final_report;
    begin
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
        $display("No errors found");
      end else begin
        $display("Errors were found");
      end
      $finish;
    end
  endtask
  ////////////////////////////////////////
  // Watchdog, well past the expected run
  initial begin
    #200000;
    failures++;
    final_report();
  end
  // Main sequence
  initial begin
    failures = 0;
    n_tests = 0;
    reset_n_i = 1'b0;
    quad_command_mode_i = 1'b0;
    nv_protect_mode_i = 1'b0;
    nv_otp_lockdown_i = 1'b0;
    nv_factory_lock_i = 1'b1;
    ev = 9'h000;
    otp_mode_i = 1'b0;
    write_protect_n_i = 1'b1;
    block_protect_field_i = 4'h0;
    prot_cmd_i = PC_NONE;
    prot_addr_i = 24'h000000;
    prot_value_i = 1'b0;
    op_req_i = 1'b0;
    op_erase_i = 1'b0;
    op_addr_i = 24'h000000;
    repeat (20) @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    chk_sec(8'h01);
    quad_command_mode_i = 1'b1;
    cmd(8'h00, 0); // Idle frame lets the new width reach the link
    chk_sec(8'h01);
    quad_command_mode_i = 1'b0;
    cmd(8'h00, 0);
    // Security write: no latch, off boundary, then proper
    cmd(OPC_WRITE_SEC, 0);
    chk_sec(8'h01);
    cmd(OPC_WENA, 0);
    `CHK("latch set", 1'b1, write_enable_latch_o)
    cmd(OPC_WRITE_SEC, 1);
    chk_sec(8'h01);
    cmd(OPC_WENA, 0);
    cmd(OPC_WRITE_SEC, 0);
    chk_sec(8'h03);
    `CHK("latch after cmd", 1'b0, write_enable_latch_o)
    `CHK("otp locked", 1'b1, otp_area1_locked_o)
    cmd(OPC_WENA, 0);
    pulse(9'h100);
    `CHK("latch cleared", 1'b0, write_enable_latch_o)
    // Block-protect mode
    block_protect_field_i = 4'h1;
    op(1'b0, 24'hff0000, 1'b1);
    op(1'b0, 24'h000000, 1'b0);
    chk_sec(8'h23);
    pulse(9'h030);
    op(1'b1, 24'hfff000, 1'b1);
    pulse(9'h080);
    chk_sec(8'h43);
    pulse(9'h0c0);
    chk_sec(8'h03);
    // Suspend and resume, each flag in turn
    for (int k = 0; k < 4; k++) begin
      pulse(9'h008 >> k);
      chk_sec(k == 0 ? 8'h0b : k == 2 ? 8'h07 : 8'h03);
    end
    otp_mode_i = 1'b1;
    op(1'b0, 24'h000000, 1'b1);
    `CHK("deny", 1'b1, array_access_deny_o)
    otp_mode_i = 1'b0;
    // Bit commands do nothing before the mode switch
    prot(PC_DYN_WRITE, 24'h000000);
    op(1'b0, 24'h000000, 1'b0);
    cmd(OPC_MODE_SEL, 0);
    chk_sec(8'h03);
    cmd(OPC_WENA, 0);
    cmd(OPC_MODE_SEL, 0);
    chk_sec(8'h83);
    `CHK("mode out", 1'b1, protect_mode_select_o)
    block_protect_field_i = 4'hf;
    op(1'b0, 24'h000000, 1'b1);
    prot(PC_GANG_UNLOCK, 24'h000000);
    op(1'b0, 24'h000000, 1'b0);
    write_protect_n_i = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    op(1'b0, 24'h000000, 1'b1);
    write_protect_n_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    prot(PC_SOL_SET, 24'h001000);
    op(1'b1, 24'h001fff, 1'b1);
    op(1'b1, 24'h002000, 1'b0);
    prot(PC_DYN_WRITE, 24'h120000);
    op(1'b0, 24'h12ffff, 1'b1);
    prot(PC_SOL_ERASE, 24'h000000);
    op(1'b1, 24'h001000, 1'b0);
    chk_sec(8'he3);
    final_report();
  end
  `undef CHK
endmodule
`default_nettype wire
